// file: mic_regs.svh
// register offsets, field positions, reset values and masks of the idle clock control block
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// byte offsets on the register bus
`define MIC_CTL1_OFS 8'h04
`define MIC_CTL2_OFS 8'h08
`define MIC_STAT_OFS 8'h40

// idle enable control 1 fields
`define MIC_CTL1_PLL_OUT_GATE 12
`define MIC_CTL1_WAKE_SEL 10
`define MIC_CTL1_TIMER_GATE 9
`define MIC_CTL1_HOST_IDLE_MODE 8
`define MIC_CTL1_PLL_IDLE_EN 7
`define MIC_CTL1_RESET 32'h0000_0400
`define MIC_CTL1_MASK 32'h0000_17FF

// idle enable control 2 fields
`define MIC_CTL2_HOST_CLK_EN 6
`define MIC_CTL2_RESET 32'h0000_0100
`define MIC_CTL2_MASK 32'h0000_09FF

// status register fields
`define MIC_STAT_CORE_IDLE 0
`define MIC_STAT_CORE_CLK 1
`define MIC_STAT_PLL_OUT_CLK 2
`define MIC_STAT_TIMER_CLK 3
`define MIC_STAT_HOST_CLK 4
`define MIC_STAT_PLL_IDLE 5
`define MIC_STAT_WAKE_PIN 6
`define MIC_STAT_IRQ_SEEN 7

// bus responses
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

`endif

// file: mic_pkg.sv
// types shared by the idle clock control block
package mic_pkg;

	// core idle state
	typedef enum logic [0:0] {
		MIC_RUN = 1'b0,
		MIC_IDLE = 1'b1
	} mic_state_t;

	// bus response code
	typedef logic [1:0] mic_resp_t;

endpackage

// file: mic_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module mic_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous input and synchronised copy
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// file: mic_idle_clk_ctl.sv
// idle clock gating control with its register bank on an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.svh"

// Overview of operation
// R1: bit 12 stops pll output clock on idle
// R2: wake select 0: wake needs low pin
// R3: wake select 1: any interrupt or wake releases
// R4: bit 9 stops core timer clock on idle
// R5: bit 8 host clock on demand else enable
// R6: software keeps bit 8 and enable before chip-idle
// R7: bit 7 lets pll idle when all quiet
// R8: bit 7 clear keeps pll active
// R9: host clock enable bit 0 stops clock
// R10: wake restarts every gated clock
module mic_idle_clk_ctl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output mic_pkg::mic_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output mic_pkg::mic_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core and system idle status
	input wire logic core_idle_req,
	input wire logic core_irq,
	input wire logic wake_event,
	input wire logic chip_idle,
	input wire logic dsp_global_idle,
	input wire logic dma_active,
	input wire logic posted_write_pending,
	input wire logic periph_clks_stopped,
	input wire logic host_port_busy,
	// external pins
	input wire logic ext_wake_pin_n,
	input wire logic test_bypass_pin,
	// clock enables and idle controls
	output logic core_clk_en,
	output logic pll_out_clk_en,
	output logic timer_clk_en,
	output logic host_port_clk_en,
	output logic pll_idle,
	output logic chip_wake
);
	import mic_pkg::*;

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic srst_n;
	logic wake_pin_n_sync;
	logic bypass_sync;
	logic [31:0] ctl1_reg;
	logic [31:0] ctl2_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire;
	logic [31:0] wr_mask;
	logic [31:0] rd_word;
	logic rd_hit;
	mic_state_t state_reg;
	mic_state_t state_next;
	logic irq_seen_reg;
	logic core_wake;
	logic host_clk_next;
	logic pll_idle_next;
	logic [31:0] status_word;

	// reset release through two flip-flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign srst_n = rst_sync_reg;

	// pin inputs pass two flip-flops before use
	mic_sync #(
		.WIDTH(2),
		.INIT(2'h3)
	) u_pin_sync (
		.clk(ref_clk),
		.rst_n(srst_n),
		.async_in({ext_wake_pin_n, test_bypass_pin}),
		.sync_out({wake_pin_n_sync, bypass_sync})
	);

	// write address and data are taken in either order and held until both are present
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// ready is high while the channel has no held item and no response is waiting
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_held_reg || (s_axi_awvalid && s_axi_awready)) && !s_axi_bvalid && !wr_fire;
			s_axi_wready <= !(w_held_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid && !wr_fire;
		end
	end

	// a write is performed once both halves are held
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

	// byte enables widened to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_strb
			assign wr_mask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
		end
	endgenerate

	// write response
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MIC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if ({awaddr_reg[7:2], 2'h0} == `MIC_CTL1_OFS || {awaddr_reg[7:2], 2'h0} == `MIC_CTL2_OFS
				|| {awaddr_reg[7:2], 2'h0} == `MIC_STAT_OFS) begin
				s_axi_bresp <= `MIC_RESP_OKAY;
			end else begin
				s_axi_bresp <= `MIC_RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// idle enable control 1, reserved bits stay zero
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			ctl1_reg <= `MIC_CTL1_RESET; // R3 R8
		end else if (wr_fire && {awaddr_reg[7:2], 2'h0} == `MIC_CTL1_OFS) begin
			ctl1_reg <= ((ctl1_reg & ~wr_mask) | (wdata_reg & wr_mask)) & `MIC_CTL1_MASK;
		end
	end

	// idle enable control 2, holds the host clock enable
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			ctl2_reg <= `MIC_CTL2_RESET; // R9
		end else if (wr_fire && {awaddr_reg[7:2], 2'h0} == `MIC_CTL2_OFS) begin
			ctl2_reg <= ((ctl2_reg & ~wr_mask) | (wdata_reg & wr_mask)) & `MIC_CTL2_MASK;
		end
	end

	// live state shown to software
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`MIC_STAT_CORE_IDLE] = (state_reg == MIC_IDLE);
		status_word[`MIC_STAT_CORE_CLK] = core_clk_en;
		status_word[`MIC_STAT_PLL_OUT_CLK] = pll_out_clk_en;
		status_word[`MIC_STAT_TIMER_CLK] = timer_clk_en;
		status_word[`MIC_STAT_HOST_CLK] = host_port_clk_en;
		status_word[`MIC_STAT_PLL_IDLE] = pll_idle;
		status_word[`MIC_STAT_WAKE_PIN] = wake_pin_n_sync;
		status_word[`MIC_STAT_IRQ_SEEN] = irq_seen_reg;
	end

	// read decode
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'h0})
			`MIC_CTL1_OFS: rd_word = ctl1_reg;
			`MIC_CTL2_OFS: rd_word = ctl2_reg;
			`MIC_STAT_OFS: rd_word = status_word;
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel, one read under way at a time
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MIC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// core wake: any interrupt, or with pin wake only an interrupt seen and the pin low
	always_comb begin
		if (ctl1_reg[`MIC_CTL1_WAKE_SEL]) begin
			core_wake = core_irq; // R3
		end else begin
			core_wake = (core_irq || irq_seen_reg) && !wake_pin_n_sync; // R2
		end
	end

	// remembers an interrupt while waiting for the wake pin
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			irq_seen_reg <= 1'b0;
		end else if (state_reg == MIC_IDLE && !core_wake) begin
			irq_seen_reg <= irq_seen_reg || core_irq; // R2
		end else begin
			irq_seen_reg <= 1'b0;
		end
	end

	// core idle state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			MIC_RUN: begin
				if (core_idle_req) begin
					state_next = MIC_IDLE;
				end
			end
			MIC_IDLE: begin
				if (core_wake) begin
					state_next = MIC_RUN; // R10
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			state_reg <= MIC_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// host port clock follows its enable, or runs on demand in idle mode
	always_comb begin
		if (ctl1_reg[`MIC_CTL1_HOST_IDLE_MODE]) begin
			host_clk_next = ctl2_reg[`MIC_CTL2_HOST_CLK_EN] && host_port_busy; // R5 R9
		end else begin
			host_clk_next = ctl2_reg[`MIC_CTL2_HOST_CLK_EN]; // R5 R9
		end
	end

	// pll idle only when enabled, the core idles and the system is quiet, with dma allowed while the bypass pin is low
	always_comb begin
		pll_idle_next = ctl1_reg[`MIC_CTL1_PLL_IDLE_EN] // R7 R8
			&& dsp_global_idle
			&& state_next == MIC_IDLE
			&& (!dma_active || !bypass_sync)
			&& !posted_write_pending
			&& periph_clks_stopped;
	end

	// clock enables, all restarted on leaving idle
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			core_clk_en <= 1'b1;
			pll_out_clk_en <= 1'b1;
			timer_clk_en <= 1'b1;
		end else begin
			core_clk_en <= (state_next == MIC_RUN); // R10
			pll_out_clk_en <= !(state_next == MIC_IDLE && ctl1_reg[`MIC_CTL1_PLL_OUT_GATE]); // R1 R10
			timer_clk_en <= !(state_next == MIC_IDLE && ctl1_reg[`MIC_CTL1_TIMER_GATE]); // R4 R10
		end
	end

	// host port clock and pll idle outputs
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			host_port_clk_en <= 1'b0;
			pll_idle <= 1'b0;
		end else begin
			host_port_clk_en <= host_clk_next;
			pll_idle <= pll_idle_next;
		end
	end

	// chip-idle release held each cycle while a wake-up condition lasts, pin-qualified when selected
	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			chip_wake <= 1'b0;
		end else begin
			chip_wake <= chip_idle && wake_event
				&& (ctl1_reg[`MIC_CTL1_WAKE_SEL] || !wake_pin_n_sync); // R2 R3
		end
	end

endmodule

`default_nettype wire

// file: mic_idle_clk_sva.sv
// port assertions for the idle clock control block
`timescale 1ns/1ps
`default_nettype none
module mic_idle_clk_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mic_pkg::mic_resp_t s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// idle status and enables
	input wire logic core_idle_req,
	input wire logic chip_idle,
	input wire logic wake_event,
	input wire logic dsp_global_idle,
	input wire logic posted_write_pending,
	input wire logic periph_clks_stopped,
	input wire logic core_clk_en,
	input wire logic pll_out_clk_en,
	input wire logic timer_clk_en,
	input wire logic pll_idle,
	input wire logic chip_wake
);
	import mic_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// idle entry, once the internal reset has surely gone
	a_idle_entry: assert property (core_clk_en && core_idle_req && $past(rst_n, 2) |=> !core_clk_en)
		else $error("core clock kept on idle");
	a_run_clocks: assert property (core_clk_en |-> pll_out_clk_en && timer_clk_en)
		else $error("gated clock without core idle");
	a_pll_quiet: assert property (pll_idle |-> $past(dsp_global_idle && periph_clks_stopped && !posted_write_pending))
		else $error("pll idle while busy");
	a_pll_awake: assert property (core_clk_en |-> !pll_idle)
		else $error("pll idle with core running");
	a_chip_wake: assert property (chip_wake |-> $past(chip_idle && wake_event))
		else $error("chip wake without cause");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule
bind mic_idle_clk_ctl mic_idle_clk_sva u_sva (.*);
`default_nettype wire

// file: mic_far_model.sv
// model of the core and system idle signals around the block
`timescale 1ns/1ps
`default_nettype none
module mic_far_model (
	// clock
	input wire logic clk,
	// core side
	output logic core_idle_req,
	output logic core_irq,
	// system side
	output logic chip_idle,
	output logic wake_event,
	output logic dsp_global_idle,
	output logic dma_active,
	output logic posted_write_pending,
	output logic periph_clks_stopped,
	output logic host_port_busy,
	// pins
	output logic ext_wake_pin_n,
	output logic test_bypass_pin
);
	// busy system, pin released high
	initial begin
		{core_idle_req, core_irq, chip_idle, wake_event, dsp_global_idle, periph_clks_stopped, host_port_busy} = '0;
		{dma_active, posted_write_pending, ext_wake_pin_n, test_bypass_pin} = '1;
	end
	// one cycle wait-for-interrupt or interrupt pulse
	task pulse(input bit irq);
		@(posedge clk);
		if (irq) core_irq <= 1'h1;
		else core_idle_req <= 1'h1;
		@(posedge clk);
		{core_idle_req, core_irq} <= 2'h0;
	endtask
	// dma activity and test bypass pin level
	task dma(input logic act, bypass);
		@(posedge clk);
		dma_active <= act;
		test_bypass_pin <= bypass;
	endtask
	// quiet system, chip wake, pin level and host port demand
	task sys(input logic q, w, pin, busy);
		@(posedge clk);
		{dsp_global_idle, periph_clks_stopped} <= {q, q};
		{dma_active, posted_write_pending} <= {!q, !q};
		{chip_idle, wake_event} <= {w, w};
		ext_wake_pin_n <= pin;
		host_port_busy <= busy;
	endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the idle clock control block
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.svh"
module tb;
	import mic_pkg::*;
	logic ref_clk = 1'h0, rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, e, seed = 32'h424C;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	mic_resp_t s_axi_bresp, s_axi_rresp, r;
	logic core_idle_req, core_irq, chip_idle, wake_event, dsp_global_idle, dma_active, posted_write_pending;
	logic periph_clks_stopped, host_port_busy, ext_wake_pin_n, test_bypass_pin;
	logic core_clk_en, pll_out_clk_en, timer_clk_en, host_port_clk_en, pll_idle, chip_wake;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	always #5 ref_clk = ~ref_clk;
	mic_idle_clk_ctl u_dut (.*);
	mic_far_model u_far (.clk(ref_clk), .*);
	// random words for the control register
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// pll output and timer enables expected while idle
	function automatic logic [1:0] gates(input logic [31:0] c);
		return {!c[`MIC_CTL1_PLL_OUT_GATE], !c[`MIC_CTL1_TIMER_GATE]};
	endfunction
	// byte strobes widened to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] s);
		for (int i = 0; i < 4; i++) lanes[i*8 +: 8] = {8{s[i]}};
	endfunction
	task chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("mismatches %0d checks %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// write; response ready raised only once it is offered
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// read; data ready raised only once data is offered
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rd(`MIC_CTL1_OFS);
		chk(d, `MIC_CTL1_RESET);
		rd(`MIC_CTL2_OFS);
		chk(d, `MIC_CTL2_RESET);
		chk(host_port_clk_en, 32'h0);
		rd(`MIC_STAT_OFS);
		chk(d, (32'h1 << `MIC_STAT_CORE_CLK) | (32'h1 << `MIC_STAT_PLL_OUT_CLK) | (32'h1 << `MIC_STAT_TIMER_CLK)
			| (32'h1 << `MIC_STAT_WAKE_PIN));
		chk(r, `MIC_RESP_OKAY);
		rd(8'hFC);
		chk(r, `MIC_RESP_SLVERR);
		// random words with random byte strobes merge into the control register
		e = `MIC_CTL1_RESET;
		repeat (8) begin
			seed = lfsr(seed);
			s_axi_wstrb <= seed[7:4];
			wr(`MIC_CTL1_OFS, seed);
			chk(r, `MIC_RESP_OKAY);
			e = ((e & ~lanes(seed[7:4])) | (seed & lanes(seed[7:4]))) & `MIC_CTL1_MASK;
			rd(`MIC_CTL1_OFS);
			chk(d, e);
		end
		s_axi_wstrb <= 4'hF;
		// unmapped write is refused and leaves the register alone
		wr(8'hF0, seed);
		chk(r, `MIC_RESP_SLVERR);
		rd(`MIC_CTL1_OFS);
		chk(d, e);
		// every gating choice, idle entry then interrupt wake with the pin high
		for (int i = 0; i < 4; i++) begin
			seed = (lfsr(seed) & 32'h7F) | 32'h400 | (i[1] ? 32'h1000 : 32'h0) | (i[0] ? 32'h200 : 32'h0);
			wr(`MIC_CTL1_OFS, seed);
			u_far.pulse(0);
			@(posedge ref_clk);
			chk({core_clk_en, pll_out_clk_en, timer_clk_en}, {1'h0, gates(seed)});
			u_far.pulse(1);
			@(posedge ref_clk);
			chk({core_clk_en, pll_out_clk_en, timer_clk_en}, 3'h7);
		end
		// pll idle only when enabled and the system is quiet
		u_far.sys(1, 0, 1, 0);
		for (int i = 0; i < 2; i++) begin
			wr(`MIC_CTL1_OFS, i ? 32'h480 : 32'h400);
			u_far.pulse(0);
			@(posedge ref_clk);
			chk(pll_idle, i);
			u_far.pulse(1);
		end
		// dma still running: pll idle only with the bypass pin low
		for (int i = 0; i < 2; i++) begin
			u_far.dma(1'h1, i[0] ? 1'h0 : 1'h1);
			repeat (3) @(posedge ref_clk);
			u_far.pulse(0);
			@(posedge ref_clk);
			chk(pll_idle, i);
			u_far.pulse(1);
		end
		u_far.dma(1'h0, 1'h1);
		// wake select clear: host clock on demand, enable kept on
		wr(`MIC_CTL1_OFS, 32'h100);
		wr(`MIC_CTL2_OFS, 32'h40);
		u_far.sys(1, 1, 1, 0);
		u_far.pulse(0);
		u_far.pulse(1);
		repeat (6) @(posedge ref_clk);
		chk({core_clk_en, chip_wake, host_port_clk_en}, 3'h0);
		u_far.sys(1, 1, 0, 1);
		repeat (6) @(posedge ref_clk);
		chk({core_clk_en, chip_wake, host_port_clk_en}, 3'h7);
		wr(`MIC_CTL1_OFS, 32'h400);
		u_far.sys(0, 1, 1, 0);
		repeat (6) @(posedge ref_clk);
		chk({chip_wake, host_port_clk_en}, 2'h3);
		conclude();
	end
endmodule
`default_nettype wire
